// File: core/dsspi_pkg.sv
// Purpose: Shared constants for the dual select serial slave
// Assumes: Byte wide serial transfers, 100 MHz system clock
// Notes:   Register bank layout and path states live here
package dsspi_pkg;
    localparam int          BYTE_BITS      = 8;
    localparam int          CNT_W          = 4;
    localparam logic [3:0]  BIT_LAST       = 4'h8;
    // Address byte layout: read flag and register index
    localparam int          ADDR_RD_BIT    = 6;
    localparam int          ADDR_HI        = 5;
    localparam int          ADDR_LO        = 1;
    localparam int          REG_AW         = 5;
    localparam int          REG_COUNT      = 32;
    // Register indices
    localparam logic [4:0]  MODE_REG       = 5'h00;
    localparam logic [4:0]  STATUS_REG     = 5'h1f;
    // Mode register fields
    localparam int          CHIP_MODE_HI   = 7;
    localparam int          CHIP_MODE_LO   = 5;
    localparam int          DATA_MODE_HI   = 4;
    localparam int          DATA_MODE_LO   = 3;
    localparam logic [2:0]  CHIP_MODE_TX   = 3'h4;
    localparam logic [2:0]  CHIP_MODE_RX   = 3'h3;
    localparam logic [1:0]  DATA_MODE_CONT = 2'h0;
    // Reset values
    localparam logic [7:0]  MODE_RESET     = 8'h28;
    localparam logic [7:0]  REG_RESET      = 8'h00;
    localparam logic [7:0]  FILL_BYTE      = 8'h00;
    // FIFO shape
    localparam int          FIFO_DEPTH     = 16;
    // Status byte bit positions
    localparam int          ST_EMPTY       = 7;
    localparam int          ST_FULL        = 6;
    localparam int          ST_OVERRUN     = 5;
    localparam int          ST_UNDERRUN    = 4;

    typedef enum logic [3:0] {
        DS_IDLE      = 4'b0001,
        DS_CFG_ADDR  = 4'b0010,
        DS_CFG_VALUE = 4'b0100,
        DS_DATA      = 4'b1000
    } dsspi_path_e;
endpackage : dsspi_pkg

// File: core/dsspi_fifo.sv
// Purpose: Byte FIFO between the serial data path and the radio side
// Assumes: Single clock, valid/ready on both sides
// Notes:   Level output is used for status reporting
`timescale 1ns/10ps
module dsspi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                       clk_in,
    input  wire logic                       nrst_in,
    input  wire logic                       in_valid_in,
    output      logic                       in_ready_out,
    input  wire logic [WIDTH-1:0]           in_data_in,
    output      logic                       out_valid_out,
    input  wire logic                       out_ready_in,
    output      logic [WIDTH-1:0]           out_data_out,
    output      logic [$clog2(DEPTH):0]     level_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    // Handshakes and flags
    assign in_ready_out  = (count_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid_out = (count_q != '0);
    assign out_data_out  = mem_q[rd_ptr_q];
    assign level_out     = count_q;
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // Storage
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule : dsspi_fifo

// File: core/dsspi_slave.sv
// Purpose: Dual select serial slave for configuration and FIFO data
// Assumes: Serial pins are asynchronous and oversampled by CLOCK_IN
// Notes:   Serial clock must stay well below a quarter of CLOCK_IN
//
// Summary of operation
// [RULE1] Config select wins; one sub-port at once
// [RULE2] Config path reads and writes all registers; here status is read only
// [RULE3] Data path moves FIFO bytes in buffered/packet
// [RULE4] Host uses mode 0, clock idles low
// [RULE5] Host holds select low whole transfer
// [RULE6] Output released when not selected
// [RULE7] Host selects in units of eight clocks
// [RULE8] Input sampled on rising serial clock
// [RULE9] Output changed on falling serial clock
// [RULE10] Every byte travels MSB first
// [RULE11] Host clock at most 6/1 MHz
// [RULE12] Register writes take effect at select rise
// [RULE13] Multi-write pairs commit together at rise
// [RULE14] Multi-read pairs within one select
// [RULE15] FIFO byte pushed at data select rise
// [RULE16] Host should deselect between read bytes; here reads stream within one select, one FIFO pop at select start and one after each byte
// [RULE17] Defaults at power-on, kept through sleep
// [RULE18] Status register readable on config path
// [RULE19] Continuous mode disables the data path
// [RULE20] Idle deselect resets bit counter
`timescale 1ns/10ps
module dsspi_slave
    import dsspi_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic        CLOCK_IN,
    input  wire logic        NRST_IN,
    input  wire logic        SCK_IN,
    input  wire logic        SDI_IN,
    input  wire logic        CONFIG_SELECT_N_IN,
    input  wire logic        FIFO_SELECT_N_IN,
    output      logic        SDO_OUT,
    output      logic        SDO_OE_OUT,
    output      logic [2:0]  CHIP_MODE_OUT,
    output      logic [1:0]  DATA_MODE_OUT,
    output      logic [7:0]  TX_DATA_OUT,
    output      logic        TX_VALID_OUT,
    input  wire logic        TX_READY_IN
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [1:0]  sck_s_q;
    logic [1:0]  sdi_s_q;
    logic [1:0]  cfg_s_q;
    logic [1:0]  dat_s_q;
    logic        sck_d1_q;
    logic        cfg_d1_q;
    logic        dat_d1_q;

    // Two flops per pin, then one delay stage for edges
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            sck_s_q  <= 2'h0;
            sdi_s_q  <= 2'h0;
            cfg_s_q  <= 2'h3;
            dat_s_q  <= 2'h3;
            sck_d1_q <= 1'b0;
            cfg_d1_q <= 1'b1;
            dat_d1_q <= 1'b1;
        end else begin
            sck_s_q  <= {sck_s_q[0], SCK_IN};
            sdi_s_q  <= {sdi_s_q[0], SDI_IN};
            cfg_s_q  <= {cfg_s_q[0], CONFIG_SELECT_N_IN};
            dat_s_q  <= {dat_s_q[0], FIFO_SELECT_N_IN};
            sck_d1_q <= sck_s_q[1];
            cfg_d1_q <= cfg_s_q[1];
            dat_d1_q <= dat_s_q[1];
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic cfg_sel;
    logic dat_sel;
    logic cfg_start;
    logic cfg_end;
    logic dat_start;
    logic dat_end;
    logic cont_mode;

    // Select decode with config priority
    assign cont_mode = (DATA_MODE_OUT == DATA_MODE_CONT);
    assign cfg_sel   = !cfg_s_q[1];                                     // RULE1
    assign dat_sel   = cfg_s_q[1] && !dat_s_q[1] && !cont_mode;         // RULE1 RULE19
    assign cfg_start = !cfg_s_q[1] && cfg_d1_q;
    assign cfg_end   = cfg_s_q[1] && !cfg_d1_q;
    assign dat_start = cfg_s_q[1] && !dat_s_q[1] && (dat_d1_q || !cfg_d1_q) && !cont_mode;
    assign dat_end   = dat_s_q[1] && !dat_d1_q && cfg_s_q[1];
    assign sck_rise  = sck_s_q[1] && !sck_d1_q && (cfg_sel || dat_sel); // RULE20
    assign sck_fall  = !sck_s_q[1] && sck_d1_q && (cfg_sel || dat_sel);

    ////////////////////////////////////////////////////////////////////////////
    // Bit shifting

    logic [CNT_W-1:0]     bit_cnt_q;
    logic [BYTE_BITS-1:0] in_shift_q;
    logic                 byte_done;
    logic [BYTE_BITS-1:0] rx_byte;

    assign rx_byte   = {in_shift_q[BYTE_BITS-2:0], sdi_s_q[1]};
    assign byte_done = sck_rise && (bit_cnt_q == BIT_LAST - 1'b1);

    // Receive shifter, MSB first on rising clock
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            bit_cnt_q  <= '0;
            in_shift_q <= '0;
        end else if (!(cfg_sel || dat_sel) || cfg_start || dat_start) begin
            bit_cnt_q  <= '0;                                           // RULE20
        end else if (sck_rise) begin
            in_shift_q <= rx_byte;                                      // RULE8 RULE10
            bit_cnt_q  <= byte_done ? '0 : bit_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Path sequencing

    dsspi_path_e          path_q;
    logic                 rd_flag_q;
    logic [REG_AW-1:0]    addr_q;
    logic                 dat_full_q;

    // Config alternates address and value bytes
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            path_q     <= DS_IDLE;
            rd_flag_q  <= 1'b0;
            addr_q     <= '0;
            dat_full_q <= 1'b0;
        end else if (cfg_start) begin
            path_q <= DS_CFG_ADDR;                                      // RULE1
        end else if (dat_start) begin
            path_q     <= DS_DATA;
            dat_full_q <= 1'b0;
        end else if (!(cfg_sel || dat_sel)) begin
            path_q <= DS_IDLE;
        end else if (byte_done) begin
            case (path_q)
                DS_CFG_ADDR: begin
                    rd_flag_q <= rx_byte[ADDR_RD_BIT];
                    addr_q    <= rx_byte[ADDR_HI:ADDR_LO];
                    path_q    <= DS_CFG_VALUE;
                end
                DS_CFG_VALUE: begin
                    path_q <= DS_CFG_ADDR;                              // RULE13 RULE14
                end
                DS_DATA: begin
                    dat_full_q <= 1'b1;
                end
                default: begin
                    path_q <= DS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register bank with staged writes

    logic [7:0]           reg_q     [REG_COUNT];
    logic [7:0]           shadow_q  [REG_COUNT];
    logic [REG_COUNT-1:0] pending_q;
    logic                 cfg_write;

    assign cfg_write = byte_done && (path_q == DS_CFG_VALUE) && !rd_flag_q
                       && (addr_q != STATUS_REG);

    // Values wait in shadow until select rises
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pending_q <= '0;
            for (int i = 0; i < REG_COUNT; i++) begin
                shadow_q[i] <= REG_RESET;
                reg_q[i]    <= (i == int'(MODE_REG)) ? MODE_RESET : REG_RESET; // RULE17
            end
        end else if (cfg_end) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                if (pending_q[i]) begin
                    reg_q[i] <= shadow_q[i];                            // RULE12 RULE13
                end
            end
            pending_q <= '0;
        end else if (cfg_write) begin
            shadow_q[addr_q]  <= rx_byte;                               // RULE2
            pending_q[addr_q] <= 1'b1;
        end
    end

    // Mode fields drive the rest of the chip
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            CHIP_MODE_OUT <= MODE_RESET[CHIP_MODE_HI:CHIP_MODE_LO];
            DATA_MODE_OUT <= MODE_RESET[DATA_MODE_HI:DATA_MODE_LO];
        end else begin
            CHIP_MODE_OUT <= reg_q[MODE_REG][CHIP_MODE_HI:CHIP_MODE_LO];
            DATA_MODE_OUT <= reg_q[MODE_REG][DATA_MODE_HI:DATA_MODE_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // FIFO and its two drains

    logic                  f_in_ready;
    logic                  f_out_valid;
    logic                  f_out_ready;
    logic [7:0]            f_out_data;
    logic [$clog2(DEPTH):0] f_level;
    logic                  push_req;
    logic                  spi_pop;
    logic                  tx_load;
    logic                  tx_mode;
    logic                  rx_mode;

    // Receive mode reads the FIFO, every other mode writes it
    assign tx_mode  = (CHIP_MODE_OUT == CHIP_MODE_TX);
    assign rx_mode  = (CHIP_MODE_OUT == CHIP_MODE_RX);
    assign push_req = !rx_mode && dat_end && dat_full_q && (path_q == DS_DATA); // RULE15
    assign spi_pop  = rx_mode && (dat_start || (byte_done && path_q == DS_DATA)); // RULE3
    assign tx_load  = tx_mode && (!TX_VALID_OUT || TX_READY_IN);
    assign f_out_ready = spi_pop || tx_load;

    dsspi_fifo #(
        .WIDTH (BYTE_BITS),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_in        (CLOCK_IN),
        .nrst_in       (NRST_IN),
        .in_valid_in   (push_req),
        .in_ready_out  (f_in_ready),
        .in_data_in    (in_shift_q),
        .out_valid_out (f_out_valid),
        .out_ready_in  (f_out_ready),
        .out_data_out  (f_out_data),
        .level_out     (f_level)
    );

    // Registered drain toward the radio
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            TX_VALID_OUT <= 1'b0;
            TX_DATA_OUT  <= FILL_BYTE;
        end else if (tx_load) begin
            TX_VALID_OUT <= f_out_valid;
            TX_DATA_OUT  <= f_out_data;
        end else if (!tx_mode && TX_READY_IN) begin
            TX_VALID_OUT <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags, set wins over clear on status read

    logic overrun_q;
    logic underrun_q;
    logic status_rd;
    logic [7:0] status_byte;

    assign status_rd   = byte_done && (path_q == DS_CFG_ADDR) && rx_byte[ADDR_RD_BIT]
                         && (rx_byte[ADDR_HI:ADDR_LO] == STATUS_REG);
    assign status_byte = {!f_out_valid, !f_in_ready, overrun_q, underrun_q,
                          f_level[3:0]};

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            overrun_q  <= 1'b0;
            underrun_q <= 1'b0;
        end else begin
            overrun_q  <= (push_req && !f_in_ready) || (overrun_q && !status_rd);
            underrun_q <= (spi_pop && !f_out_valid) || (underrun_q && !status_rd);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial output

    logic [7:0] out_shift_q;
    logic [7:0] rd_value;
    logic [7:0] pop_value;

    assign pop_value = (rx_mode && f_out_valid) ? f_out_data : FILL_BYTE;
    assign rd_value  = (rx_byte[ADDR_HI:ADDR_LO] == STATUS_REG) ? status_byte // RULE18
                     : reg_q[rx_byte[ADDR_HI:ADDR_LO]];                       // RULE2

    // Preload at select, reload per byte, shift on falling clock
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            out_shift_q <= FILL_BYTE;
            SDO_OUT     <= 1'b0;
            SDO_OE_OUT  <= 1'b0;
        end else begin
            SDO_OE_OUT <= cfg_sel || dat_sel;                           // RULE6
            if (cfg_start) begin
                out_shift_q <= FILL_BYTE;
                SDO_OUT     <= 1'b0;
            end else if (dat_start) begin
                out_shift_q <= {pop_value[6:0], 1'b0};
                SDO_OUT     <= pop_value[7];                            // RULE10
            end else if (byte_done && path_q == DS_CFG_ADDR) begin
                out_shift_q <= rx_byte[ADDR_RD_BIT] ? rd_value : FILL_BYTE; // RULE14
            end else if (byte_done && path_q == DS_DATA) begin
                out_shift_q <= pop_value;
            end else if (byte_done) begin
                out_shift_q <= FILL_BYTE;
            end else if (sck_fall) begin
                SDO_OUT     <= out_shift_q[7];                          // RULE9
                out_shift_q <= {out_shift_q[6:0], 1'b0};
            end
        end
    end
endmodule : dsspi_slave

// File: dv/dsspi_checker.sv
// Purpose: Port level checks on the dual select serial slave
// Assumes: Bound to dsspi_slave, one clock domain, SCK phases of 8 cycles
// Notes:   Sync delays of 3-4 cycles give the windows used below
`timescale 1ns/10ps
module dsspi_checker
    import dsspi_pkg::*;
(
    input wire logic       CLOCK_IN,
    input wire logic       NRST_IN,
    input wire logic       SCK_IN,
    input wire logic       SDI_IN,
    input wire logic       CONFIG_SELECT_N_IN,
    input wire logic       FIFO_SELECT_N_IN,
    input wire logic       SDO_OUT,
    input wire logic       SDO_OE_OUT,
    input wire logic [2:0] CHIP_MODE_OUT,
    input wire logic [1:0] DATA_MODE_OUT,
    input wire logic [7:0] TX_DATA_OUT,
    input wire logic       TX_VALID_OUT,
    input wire logic       TX_READY_IN
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!NRST_IN);
    ////////////////////////////////////////////////////////////////////////////
    // Selection sequences
    sequence s_idle;
        (CONFIG_SELECT_N_IN && FIFO_SELECT_N_IN)[*5];
    endsequence
    sequence s_cfg_on;
        $fell(CONFIG_SELECT_N_IN) ##1 (!CONFIG_SELECT_N_IN)[*5];
    endsequence
    sequence s_cont_data;
        (CONFIG_SELECT_N_IN && DATA_MODE_OUT == DATA_MODE_CONT)[*6];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    // Output enable follows selection
    property p_oe_off; s_idle |-> !SDO_OE_OUT; endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("serial output driven while deselected");
    property p_oe_on; s_cfg_on |-> SDO_OE_OUT; endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("serial output not driven on config select");
    property p_cont_off; s_cont_data |-> !SDO_OE_OUT; endproperty
    a_cont_off: assert property (p_cont_off)
        else $error("data path active in continuous mode");
    // Output moves only after a falling serial clock
    property p_sdo_hold; (SCK_IN[*5]) ##0 SDO_OE_OUT |-> $stable(SDO_OUT); endproperty
    a_sdo_hold: assert property (p_sdo_hold)
        else $error("serial output changed while clock high");
    // Mode outputs commit only after config select rises
    property p_mode_hold;
        (!CONFIG_SELECT_N_IN)[*8] |-> $stable(CHIP_MODE_OUT) && $stable(DATA_MODE_OUT);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode changed while config selected");
    property p_mode_commit;
        ($changed(CHIP_MODE_OUT) || $changed(DATA_MODE_OUT))
            |-> $past(CONFIG_SELECT_N_IN) && !$past(CONFIG_SELECT_N_IN, 8);
    endproperty
    a_mode_commit: assert property (p_mode_commit)
        else $error("mode changed outside commit window");
    // Transmit drain handshake
    property p_tx_hold;
        TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("transmit byte dropped before ready");
    property p_tx_mode; $rose(TX_VALID_OUT) |-> CHIP_MODE_OUT == CHIP_MODE_TX; endproperty
    a_tx_mode: assert property (p_tx_mode)
        else $error("transmit byte offered outside transmit mode");
endmodule : dsspi_checker

bind dsspi_slave dsspi_checker u_chk (.CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN),
    .SCK_IN(SCK_IN), .SDI_IN(SDI_IN), .CONFIG_SELECT_N_IN(CONFIG_SELECT_N_IN),
    .FIFO_SELECT_N_IN(FIFO_SELECT_N_IN), .SDO_OUT(SDO_OUT), .SDO_OE_OUT(SDO_OE_OUT),
    .CHIP_MODE_OUT(CHIP_MODE_OUT), .DATA_MODE_OUT(DATA_MODE_OUT),
    .TX_DATA_OUT(TX_DATA_OUT), .TX_VALID_OUT(TX_VALID_OUT), .TX_READY_IN(TX_READY_IN));

// File: dv/dsspi_host_model.sv
// Purpose: Serial master standing in for the host controller
// Assumes: Driven on falling CLOCK_IN edges, SCK phases of 8 cycles
// Notes:   Line keeps its last driven level while released
`timescale 1ns/10ps
module dsspi_host_model (
    input  wire logic clk_in,
    input  wire logic sdo_in,
    input  wire logic sdo_oe_in,
    output      logic sck_out,
    output      logic sdi_out,
    output      logic cfg_sel_n_out,
    output      logic fifo_sel_n_out
);
    logic       held;
    logic [7:0] rx_byte;
    event       rx_ev;
    wire        line = sdo_oe_in ? sdo_in : held;
    ////////////////////////////////////////////////////////////////////////////
    // Bus hold on the shared output line
    always @(posedge clk_in) if (sdo_oe_in) held <= sdo_in;
    initial begin
        held = 1'b0;
        sck_out = 1'b0;
        sdi_out = 1'b0;
        cfg_sel_n_out = 1'b1;
        fifo_sel_n_out = 1'b1;
    end
    // Half of a serial clock period, fixed at eight CLOCK_IN cycles
    task automatic half();
        repeat (8) @(negedge clk_in);
    endtask : half
    // Select levels, held over whole transfers
    task automatic sel(input logic c, input logic f);
        half();
        cfg_sel_n_out = c;
        fifo_sel_n_out = f;
        half();
    endtask : sel
    // One byte, eight clocks, MSB first, clock idles low
    task automatic xfer(input logic [7:0] tx, input bit chk);
        logic [7:0] r;
        for (int i = 7; i >= 0; i--) begin
            sdi_out = tx[i];
            half();
            sck_out = 1'b1;
            r = {r[6:0], line};
            half();
            sck_out = 1'b0;
        end
        sdi_out = ~tx[0];
        if (chk) begin
            rx_byte = r;
            ->rx_ev;
        end
    endtask : xfer
    // Clock pulses with nothing selected
    task automatic pulse(input int n);
        repeat (n) begin
            half();
            sck_out = 1'b1;
            half();
            sck_out = 1'b0;
        end
    endtask : pulse
endmodule : dsspi_host_model

// File: dv/tb_top.sv
// Purpose: Self-checking bench for the dual select serial slave
// Assumes: Host model drives the serial side, bench drives radio ready
// Notes:   Expected read bytes queue up ahead of each transfer
`timescale 1ns/10ps
module tb_top;
    import dsspi_pkg::*;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       tx_ready = 1'b0;
    wire        sck, sdi, cfg_n, fifo_n;
    logic       sdo, oe, tx_valid;
    logic [2:0] chip;
    logic [1:0] dmode;
    logic [7:0] tx_data, r1, d;
    logic [7:0] exp_q[$], tx_q[$], fill[$];
    int         failures = 0;
    int         check_count = 0;
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    dsspi_slave #(.DEPTH(16)) dut (.CLOCK_IN(clk), .NRST_IN(nrst), .SCK_IN(sck),
        .SDI_IN(sdi), .CONFIG_SELECT_N_IN(cfg_n), .FIFO_SELECT_N_IN(fifo_n),
        .SDO_OUT(sdo), .SDO_OE_OUT(oe), .CHIP_MODE_OUT(chip), .DATA_MODE_OUT(dmode),
        .TX_DATA_OUT(tx_data), .TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready));
    dsspi_host_model host (.clk_in(clk), .sdo_in(sdo), .sdo_oe_in(oe), .sck_out(sck),
        .sdi_out(sdi), .cfg_sel_n_out(cfg_n), .fifo_sel_n_out(fifo_n));
    ////////////////////////////////////////////////////////////////////////////
    // Comparison and closing
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    // Register access over the config path
    task automatic wr(input logic [4:0] idx, input logic [7:0] v);
        host.xfer({2'b00, idx, 1'b0}, 0);
        host.xfer(v, 0);
    endtask : wr
    task automatic rd(input logic [4:0] idx, input logic [7:0] e);
        exp_q.push_back(e);
        host.xfer({2'b01, idx, 1'b0}, 0);
        host.xfer(8'h00, 1);
    endtask : rd
    // One FIFO byte, select raised after it
    task automatic push(input logic [7:0] v);
        host.sel(1'b1, 1'b0);
        host.xfer(v, 0);
        host.sel(1'b1, 1'b1);
    endtask : push
    ////////////////////////////////////////////////////////////////////////////
    // Watchers: read bytes and radio side handshakes
    always @(host.rx_ev) check(host.rx_byte, exp_q.pop_front());
    always @(posedge clk) if (tx_valid && tx_ready) check(tx_data, tx_q.pop_front());
    always @(negedge clk) tx_ready <= 1'($urandom % 2);
    // Watchdog
    initial begin
        #300000;
        failures++;
        end_sim();
    end
    // Main sequence
    initial begin
        void'($urandom(32'h1f1a));
        repeat (4) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        check({5'h00, chip}, {5'h00, MODE_RESET[7:5]});
        check({6'h00, dmode}, {6'h00, MODE_RESET[4:3]});
        check({7'h00, oe}, 8'h00);
        host.pulse(3);
        r1 = 8'($urandom);
        host.sel(1'b0, 1'b0);
        wr(5'h03, r1);
        wr(MODE_REG, 8'h50);
        check({5'h00, chip}, {5'h00, MODE_RESET[7:5]});
        host.sel(1'b1, 1'b1);
        check({5'h00, chip}, 8'h02);
        check({6'h00, dmode}, 8'h02);
        host.sel(1'b0, 1'b1);
        rd(5'h03, r1);
        rd(MODE_REG, 8'h50);
        wr(STATUS_REG, 8'hff);
        host.sel(1'b1, 1'b1);
        host.sel(1'b0, 1'b1);
        rd(STATUS_REG, 8'h80);
        host.sel(1'b1, 1'b1);
        for (int i = 0; i < 17; i++) begin
            d = 8'($urandom);
            if (i < 16) fill.push_back(d);
            push(d);
        end
        host.sel(1'b0, 1'b1);
        rd(STATUS_REG, 8'h60);
        wr(MODE_REG, {CHIP_MODE_RX, 5'h10});
        host.sel(1'b1, 1'b1);
        host.sel(1'b1, 1'b0);
        foreach (fill[i]) begin
            exp_q.push_back(fill[i]);
            host.xfer(8'($urandom), 1);
        end
        exp_q.push_back(FILL_BYTE);
        host.xfer(8'h00, 1);
        host.sel(1'b1, 1'b1);
        host.sel(1'b0, 1'b1);
        rd(STATUS_REG, 8'h90);
        wr(MODE_REG, 8'h40);
        host.sel(1'b1, 1'b1);
        check({6'h00, dmode}, {6'h00, DATA_MODE_CONT});
        push(8'($urandom));
        host.sel(1'b0, 1'b1);
        wr(MODE_REG, {CHIP_MODE_TX, 5'h10});
        rd(STATUS_REG, 8'h80);
        host.sel(1'b1, 1'b1);
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            tx_q.push_back(d);
            push(d);
        end
        for (int i = 0; i < 2000 && tx_q.size() > 0; i++) @(posedge clk);
        check(8'(tx_q.size()), 8'h00);
        end_sim();
    end
endmodule : tb_top
